// ### bench/rtrsv_mem_model.sv
// program memory model with stalls and injected read faults
`timescale 1ns/1ps
module rtrsv_mem_model (
  // clock and mode
  input wire logic clk,
  input wire logic slow,
  // memory port
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  output logic mem_ready,
  output logic [15:0] mem_rdata
);
  int bad = 0;
  logic [15:0] bad_addr = 16'h0;
  logic [15:0] m [logic [15:0]];
  initial mem_ready = 1'h1;
  initial mem_rdata = 16'h0;
  // unwritten cells read as the inverted address; idle read data keeps toggling
  always @(posedge clk) begin
    mem_ready <= !slow || !mem_ready;
    if (mem_we) m[mem_addr] = mem_wdata;
    if (mem_re && m.exists(mem_addr)) mem_rdata <= m[mem_addr];
    else if (mem_re) mem_rdata <= ~mem_addr;
    else mem_rdata <= ~mem_rdata;
    if (mem_re && bad > 0 && mem_addr == bad_addr) begin
      mem_rdata <= m[mem_addr] ^ 16'h0001;
      bad--;
    end
  end
endmodule

// ### bench/rtrsv_sva.sv
// assertion checker for the reprogram status / verify handler
`timescale 1ns/1ps
module rtrsv_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // message events
  input wire logic msg_start,
  input wire logic [4:0] msg_sa,
  input wire logic msg_tr,
  input wire logic msg_end,
  input wire logic msg_err,
  // transmit side
  input wire logic tx_req,
  input wire logic [15:0] tx_word,
  input wire logic tx_valid,
  input wire logic [15:0] resp_status,
  // memory and register port
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [1:0] reg_addr,
  input wire logic reg_re,
  input wire logic [15:0] reg_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // set while an accepted load is being received, so dropped messages do not count
  logic load_rx;
  always_ff @(posedge clk) begin
    if (reset || msg_end) begin
      load_rx <= 1'b0;
    end else if ($rose(resp_status[9])) begin
      load_rx <= 1'b1;
    end
  end
  property p_tx_ans; tx_valid |-> $past(tx_req); endproperty
  a_tx_ans: assert property (p_tx_ans) else $error("tx_valid unasked");
  property p_tx_hold; !$past(tx_req) |-> $stable(tx_word); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx_word moved");
  property p_resp_bits; (resp_status & 16'hfdff) == 16'h0; endproperty
  a_resp_bits: assert property (p_resp_bits) else $error("stray status bit");
  property p_wait_cause;
    $rose(resp_status[9]) |-> $past(msg_start && msg_sa == rtrsv_pkg::SA_LOAD && !msg_tr);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait without load");
  // a load that ends with a message error frees the status at once and does not write memory in the next cycle
  property p_wait_bad;
    msg_end && msg_err && load_rx && resp_status[9] |=> !resp_status[9] && !mem_we;
  endproperty
  a_wait_bad: assert property (p_wait_bad) else $error("bad load kept wait");
  property p_reg_idle; !$past(reg_re) |-> reg_rdata == 16'h0; endproperty
  a_reg_idle: assert property (p_reg_idle) else $error("read data outside slot");
  property p_reg_gap; reg_re && reg_addr == 2'h3 |=> reg_rdata == 16'h0; endproperty
  a_reg_gap: assert property (p_reg_gap) else $error("unmapped read not zero");
  property p_mem_excl; !(mem_we && mem_re) ##1 !(mem_we && $past(mem_we)); endproperty
  a_mem_excl: assert property (p_mem_excl) else $error("memory strobes clash");
  c_tx: cover property (tx_valid);
  c_wait_end: cover property ($fell(resp_status[9]));
  c_read: cover property (mem_re && !mem_we);
endmodule

bind rtrsv_top rtrsv_sva u_sva (.clk, .reset, .msg_start, .msg_sa, .msg_tr, .msg_end, .msg_err,
  .tx_req, .tx_word, .tx_valid, .resp_status, .mem_we, .mem_re, .reg_addr, .reg_re, .reg_rdata);

// ### bench/tb_rtrsv_top.sv
// self-checking bench for the reprogram status / verify handler
`timescale 1ns/1ps
module tb_rtrsv_top;
  logic clk = '0, reset = '1, msg_start = '0, msg_tr = '0, rx_valid = '0, msg_end = '0;
  logic msg_err = '0, tx_req = '0, reg_we = '0, reg_re = '0, slow = '0;
  logic tx_valid, mem_ready, mem_we, mem_re;
  logic [4:0] msg_sa = '0, msg_wc = '0;
  logic [1:0] reg_addr = '0;
  logic [15:0] rx_word = '0, reg_wdata = '0, tx_word, resp_status, mem_rdata, mem_addr;
  logic [15:0] mem_wdata, reg_rdata, d, q[$], r[$];
  int n_errors = 0, num_checks = 0, cyc = 0;
  rtrsv_top dut (.clk, .reset, .msg_start, .msg_sa, .msg_tr, .msg_wc, .rx_valid, .rx_word,
    .msg_end, .msg_err, .tx_req, .tx_word, .tx_valid, .resp_status, .mem_ready, .mem_rdata,
    .mem_addr, .mem_wdata, .mem_we, .mem_re, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata);
  rtrsv_mem_model mem (.clk, .slow, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_ready,
    .mem_rdata);
  initial forever #5 clk = ~clk;
  // the whole run takes a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task summarize;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task reg_rd(input logic [1:0] a);
    @(posedge clk) reg_re <= 1'h1;
    reg_addr <= a;
    @(posedge clk) reg_re <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task reg_wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge clk) reg_we <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk) reg_we <= 1'h0;
  endtask
  task rx_msg(input logic [4:0] sa, input logic err);
    @(posedge clk) msg_start <= 1'h1;
    msg_sa <= sa;
    msg_tr <= 1'h0;
    msg_wc <= 5'(q.size());
    foreach (q[i]) begin
      @(posedge clk) msg_start <= 1'h0;
      rx_valid <= 1'h1;
      rx_word <= q[i];
    end
    @(posedge clk) rx_valid <= 1'h0;
    msg_end <= 1'h1;
    msg_err <= err;
    @(posedge clk) msg_end <= 1'h0;
    msg_err <= 1'h0;
  endtask
  task tx_msg(input logic [4:0] sa, input int n);
    r = {};
    @(posedge clk) msg_start <= 1'h1;
    msg_sa <= sa;
    msg_tr <= 1'h1;
    msg_wc <= 5'(n);
    @(posedge clk) msg_start <= 1'h0;
    repeat (n) begin
      tx_req <= 1'h1;
      @(posedge clk) tx_req <= 1'h0;
      #1 chk(16'(tx_valid), 16'h1);
      r.push_back(tx_word);
      @(posedge clk);
    end
  endtask
  task wait_idle;
    int i;
    for (i = 0; i < 200; i++) begin
      reg_rd(rtrsv_pkg::REG_STATUS);
      if (d[0] === 1'h1 && d[4] === 1'h0) break;
    end
    chk(16'(i < 200), 16'h1);
  endtask
  function automatic logic [15:0] expm(input logic [15:0] x);
    return x == 16'h0102 ? 16'h1236 : x == 16'h0902 ? 16'h8765 : ~x;
  endfunction
  task t_reset;
    reg_rd(rtrsv_pkg::REG_CTRL);
    chk(d, 16'h1);
    reg_wr(2'h3, 16'hffff);
    reg_rd(2'h3);
    chk(d, 16'h0);
    tx_msg(rtrsv_pkg::SA_LOAD, 4);
    chk(r[0], 16'h1);
    chk(r[3], 16'h0);
  endtask
  task t_bad_loads;
    for (int i = 0; i < 2; i++) begin
      q = {16'h0200, 16'h1111, 16'h2222, i == 0 ? 16'hcccd : 16'h0, 16'h3333};
      rx_msg(rtrsv_pkg::SA_LOAD, i == 0);
      wait_idle();
      tx_msg(rtrsv_pkg::SA_LOAD, 1);
      chk(r[0], 16'h000f);
      chk(16'(mem.m.exists(16'h0200)), 16'h0);
    end
  endtask
  task t_loads;
    logic [15:0] a, d1, cs;
    // each try fails once per injected fault, so k faults give attempt code k, three meaning failure
    for (int k = 0; k < 4; k++) begin
      a = 16'h0100 + 16'(k);
      d1 = 16'h1234 + 16'(k);
      cs = 16'h0 - d1 - 16'h8765;
      mem.bad = k;
      mem.bad_addr = a;
      q = {a, d1, 16'h8765, cs, d1 ^ 16'h8765};
      rx_msg(rtrsv_pkg::SA_LOAD, 1'h0);
      #1 chk(16'(resp_status[9]), 16'h1);
      // polled while programming: only the ready bit is judged
      tx_msg(rtrsv_pkg::SA_LOAD, 1);
      chk(16'(r[0][0]), 16'h0);
      wait_idle();
      chk(d, k == 3 ? 16'h7 : 16'(2 * k + 1));
      tx_msg(rtrsv_pkg::SA_LOAD, 4);
      chk(r[0], k == 3 ? 16'h7 : 16'(2 * k + 1));
      chk(r[1], cs);
      chk(r[2], d1 ^ 16'h8765);
      chk(r[3], a);
      if (k < 3) chk(mem.m[a + 16'h0800], 16'h8765);
    end
    reg_wr(rtrsv_pkg::REG_CTRL, 16'h0);
    rx_msg(rtrsv_pkg::SA_LOAD, 1'h0);
    #1 chk(16'(resp_status[9]), 16'h0);
    tx_msg(rtrsv_pkg::SA_LOAD, 4);
    chk(r[3], 16'h0103);
    reg_wr(rtrsv_pkg::REG_CTRL, 16'h1);
    // two rejected and four accepted loads; the disabled one is not counted
    reg_rd(rtrsv_pkg::REG_LOADS);
    chk(d, 16'h6);
  endtask
  task t_readback;
    int cnt[2] = '{2, 12};
    foreach (cnt[i]) begin
      q = {16'h0102, 16'(cnt[i]), 16'h0 - 16'h0102 - 16'(cnt[i])};
      slow <= cnt[i] == 12;
      rx_msg(rtrsv_pkg::SA_VERIFY, 1'h0);
      wait_idle();
      tx_msg(rtrsv_pkg::SA_VERIFY, cnt[i] + 1);
      chk(r[0], 16'h0102);
      for (int j = 1; j <= cnt[i]; j++) begin
        chk(r[j], expm(16'h0102 + 16'(j - 1) * 16'h0800));
      end
    end
    slow <= 1'h0;
    q = {16'h0500, 16'h0002, 16'h0};
    rx_msg(rtrsv_pkg::SA_VERIFY, 1'h0);
    wait_idle();
    tx_msg(rtrsv_pkg::SA_VERIFY, 3);
    chk(r[0], 16'h0102);
    chk(r[1], 16'h1236);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    t_reset();
    t_bad_loads();
    t_loads();
    t_readback();
    summarize();
  end
endmodule

// ### verilog/rtrsv_pkg.sv
// shared constants and state types for the reprogram status / verify handler
package rtrsv_pkg;
  // subaddresses
  localparam logic [4:0] SA_LOAD = 5'h1a;
  localparam logic [4:0] SA_VERIFY = 5'h1b;
  // address step between consecutive memory words of one message
  localparam logic [15:0] ADDR_STRIDE = 16'h0800;
  // status response word: wait flag position
  localparam int WAIT_BIT = 9;
  // status data word 1 field positions
  localparam int READY_BIT = 0;
  localparam int ATTEMPT_LSB = 1;
  localparam int RX_ERR_BIT = 3;
  // programming attempt codes
  localparam logic [1:0] ATTEMPT_FIRST = 2'h0;
  localparam logic [1:0] ATTEMPT_LAST_TRY = 2'h2;
  localparam logic [1:0] ATTEMPT_FAIL = 2'h3;
  // message sizes in words
  localparam logic [5:0] LOAD_MIN_WORDS = 6'h04;
  localparam logic [5:0] LOAD_TAIL_WORDS = 6'h03;
  localparam logic [5:0] SUM_LAG = 6'h02;
  localparam logic [5:0] PREP_WORDS = 6'h03;
  localparam logic [5:0] WC_FULL = 6'h20;
  localparam logic [5:0] STAT_WORDS = 6'h04;
  localparam logic [15:0] READBACK_MAX = 16'h001f;
  // register port offsets and reset values
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_LOADS = 2'h2;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STATUS_WAIT_BIT = 4;
  localparam int STATUS_BUSY_BIT = 5;

  typedef enum logic [3:0] {
    S_IDLE, S_LOAD, S_PREP_RX, S_P_WR, S_P_RD, S_P_WAIT, S_P_CMP, S_R_RD, S_R_WAIT, S_R_CAP
  } rtrsv_state_e;

  typedef enum logic [1:0] {
    K_NONE, K_STAT, K_FETCH
  } rtrsv_tx_kind_e;
endpackage

// ### verilog/rtrsv_top.sv
// remote-terminal handler for load status reporting and memory readback
// Function
// - transmit on subaddress 1AH returns the four status data words.
// - wait flag is 1 while the status data words are stale.
// - word 1 bit 3 set when the last load arrived with error.
// - programming of one load is tried at most three times.
// - word 1 bits 1-2: 00/01/10 try that succeeded, 11 failure.
// - word 1 bit 0 is ready: 1 when idle, 0 while busy.
// - word 2 is the terminal's own two's-complement checksum of load data.
// - word 3 is the XOR of all load data words.
// - word 4 echoes the starting address of the last load.
// - receive on subaddress 1BH prepares memory words for readback.
// - prepare word 1 is first address; each next word is 800H higher.
// - prepare word 3 is the negated 16-bit sum of words 1 and 2.
// - transmit on subaddress 1BH returns the prepared words.
// - first fetch reply word is the start address, then memory words.
// - fetch reply words 2 to N carry the memory contents.
// - wait flag sits at status response bit 9.
// - load is receive on 1AH: address, data, checksum, parity.
// - load checksum is negated 16-bit sum of data words.
`timescale 1ns/1ps
module rtrsv_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // message events from the bus terminal core
  input wire logic msg_start,
  input wire logic [4:0] msg_sa,
  input wire logic msg_tr,
  input wire logic [4:0] msg_wc,
  input wire logic rx_valid,
  input wire logic [15:0] rx_word,
  input wire logic msg_end,
  input wire logic msg_err,
  // transmit words to the bus terminal core
  input wire logic tx_req,
  output logic [15:0] tx_word,
  output logic tx_valid,
  output logic [15:0] resp_status,
  // program memory
  input wire logic mem_ready,
  input wire logic [15:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata
);
  typedef struct packed {
    rtrsv_pkg::rtrsv_state_e st;
    rtrsv_pkg::rtrsv_tx_kind_e txk;
    logic en;
    logic waitf;
    logic rx_err;
    logic [1:0] attempt;
    logic [15:0] s_cks;
    logic [15:0] s_par;
    logic [15:0] s_start;
    logic [31:0][15:0] wbuf;
    logic [5:0] rcnt;
    logic [5:0] wc;
    logic [15:0] sum;
    logic [15:0] par;
    logic [15:0] pw0;
    logic [15:0] pw1;
    logic [15:0] pw2;
    logic [5:0] widx;
    logic [1:0] tries;
    logic fail;
    logic [15:0] addr;
    logic [5:0] left;
    logic [5:0] txi;
    logic [15:0] loads;
    logic [15:0] tx_word;
    logic tx_valid;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic mem_we;
    logic mem_re;
    logic [15:0] reg_rdata;
    logic [15:0] resp_status;
  } rtrsv_state_s;

  rtrsv_state_s q;
  rtrsv_state_s next_q;

  always_comb begin
    logic [15:0] word1;
    logic [15:0] cks;
    logic [4:0] lag_idx;
    logic load_ok;
    logic [15:0] prep_cks;
    next_q = q;
    word1 = 16'h0000;
    cks = 16'h0000;
    lag_idx = 5'h00;
    load_ok = 1'b0;
    prep_cks = 16'h0000;
    next_q.tx_valid = 1'b0;
    next_q.mem_we = 1'b0;
    next_q.mem_re = 1'b0;
    next_q.reg_rdata = 16'h0000;

    // upper bits stay zero; the controller does not look at them
    word1[rtrsv_pkg::RX_ERR_BIT] = q.rx_err;
    word1[rtrsv_pkg::ATTEMPT_LSB +: 2] = q.attempt;
    word1[rtrsv_pkg::READY_BIT] = (q.st == rtrsv_pkg::S_IDLE);

    // transmit side runs in any state so status can be polled while busy
    if (msg_start && msg_tr) begin
      next_q.txi = 6'h00;
      if (msg_sa == rtrsv_pkg::SA_LOAD) begin
        next_q.txk = rtrsv_pkg::K_STAT;
      end else if (msg_sa == rtrsv_pkg::SA_VERIFY) begin
        next_q.txk = rtrsv_pkg::K_FETCH;
      end else begin
        next_q.txk = rtrsv_pkg::K_NONE;
      end
    end else if (tx_req && q.txk != rtrsv_pkg::K_NONE) begin
      next_q.tx_valid = 1'b1;
      next_q.txi = q.txi + 6'h01;
      if (q.txk == rtrsv_pkg::K_FETCH) begin
        // slot 0 holds the start address, slots 1.. the memory words
        next_q.tx_word = q.txi[5] ? 16'h0000 : q.wbuf[q.txi[4:0]];
      end else begin
        unique case (q.txi)
          6'h00: next_q.tx_word = word1;
          6'h01: next_q.tx_word = q.s_cks;
          6'h02: next_q.tx_word = q.s_par;
          6'h03: next_q.tx_word = q.s_start;
          default: next_q.tx_word = 16'h0000;
        endcase
      end
    end

    unique case (q.st)
      rtrsv_pkg::S_IDLE: begin
        if (msg_start && !msg_tr && q.en) begin
          next_q.rcnt = 6'h00;
          next_q.wc = (msg_wc == 5'h00) ? rtrsv_pkg::WC_FULL : {1'b0, msg_wc};
          next_q.sum = 16'h0000;
          next_q.par = 16'h0000;
          if (msg_sa == rtrsv_pkg::SA_LOAD) begin
            next_q.st = rtrsv_pkg::S_LOAD;
            next_q.waitf = 1'b1;
          end else if (msg_sa == rtrsv_pkg::SA_VERIFY) begin
            next_q.st = rtrsv_pkg::S_PREP_RX;
          end
        end
      end
      rtrsv_pkg::S_LOAD: begin
        if (rx_valid && !q.rcnt[5]) begin
          next_q.wbuf[q.rcnt[4:0]] = rx_word;
          next_q.rcnt = q.rcnt + 6'h01;
          // sum lags two words so checksum and parity words drop out
          if (q.rcnt > rtrsv_pkg::SUM_LAG) begin
            lag_idx = 5'(q.rcnt - rtrsv_pkg::SUM_LAG);
            next_q.sum = q.sum + q.wbuf[lag_idx];
            next_q.par = q.par ^ q.wbuf[lag_idx];
          end
        end else if (msg_end) begin
          cks = (q.sum ^ 16'hffff) + 16'h0001;
          load_ok = !msg_err && q.rcnt == q.wc && q.rcnt >= rtrsv_pkg::LOAD_MIN_WORDS
            && q.wbuf[5'(q.rcnt - rtrsv_pkg::SUM_LAG)] == cks
            && q.wbuf[5'(q.rcnt - 6'h01)] == q.par;
          if (load_ok) begin
            next_q.st = rtrsv_pkg::S_P_WR;
            next_q.widx = 6'h01;
            next_q.tries = rtrsv_pkg::ATTEMPT_FIRST;
            next_q.fail = 1'b0;
            next_q.addr = q.wbuf[0];
          end else begin
            // a bad load is not written; report it at once
            next_q.st = rtrsv_pkg::S_IDLE;
            next_q.rx_err = 1'b1;
            next_q.attempt = rtrsv_pkg::ATTEMPT_FAIL;
            next_q.s_cks = cks;
            next_q.s_par = q.par;
            next_q.s_start = q.wbuf[0];
            next_q.waitf = 1'b0;
            next_q.loads = q.loads + 16'h0001;
          end
        end
      end
      rtrsv_pkg::S_P_WR: begin
        if (mem_ready) begin
          next_q.mem_we = 1'b1;
          next_q.mem_addr = q.addr;
          next_q.mem_wdata = q.wbuf[q.widx[4:0]];
          next_q.st = rtrsv_pkg::S_P_RD;
        end
      end
      rtrsv_pkg::S_P_RD: begin
        if (mem_ready) begin
          next_q.mem_re = 1'b1;
          next_q.st = rtrsv_pkg::S_P_WAIT;
        end
      end
      rtrsv_pkg::S_P_WAIT: begin
        next_q.st = rtrsv_pkg::S_P_CMP;
      end
      rtrsv_pkg::S_P_CMP: begin
        next_q.fail = q.fail || (mem_rdata != q.wbuf[q.widx[4:0]]);
        next_q.addr = q.addr + rtrsv_pkg::ADDR_STRIDE;
        next_q.widx = q.widx + 6'h01;
        next_q.st = rtrsv_pkg::S_P_WR;
        if (q.widx == q.rcnt - rtrsv_pkg::LOAD_TAIL_WORDS) begin
          if (next_q.fail && q.tries != rtrsv_pkg::ATTEMPT_LAST_TRY) begin
            // whole message again, never more than three passes
            next_q.tries = q.tries + 2'h1;
            next_q.fail = 1'b0;
            next_q.widx = 6'h01;
            next_q.addr = q.wbuf[0];
          end else begin
            // status words change here after the last pass, or above when a load is rejected
            next_q.st = rtrsv_pkg::S_IDLE;
            next_q.rx_err = 1'b0;
            next_q.attempt = next_q.fail ? rtrsv_pkg::ATTEMPT_FAIL : q.tries;
            next_q.s_cks = (q.sum ^ 16'hffff) + 16'h0001;
            next_q.s_par = q.par;
            next_q.s_start = q.wbuf[0];
            next_q.waitf = 1'b0;
            next_q.loads = q.loads + 16'h0001;
          end
        end
      end
      rtrsv_pkg::S_PREP_RX: begin
        if (rx_valid) begin
          next_q.rcnt = q.rcnt + 6'h01;
          unique case (q.rcnt)
            6'h00: next_q.pw0 = rx_word;
            6'h01: next_q.pw1 = rx_word;
            6'h02: next_q.pw2 = rx_word;
            // an over-long request parks the count above three so it is refused
            default: next_q.rcnt = rtrsv_pkg::PREP_WORDS + 6'h01;
          endcase
        end else if (msg_end) begin
          prep_cks = ((q.pw0 + q.pw1) ^ 16'hffff) + 16'h0001;
          next_q.st = rtrsv_pkg::S_IDLE;
          // only a clean, correctly summed request touches the buffer
          if (!msg_err && q.rcnt == rtrsv_pkg::PREP_WORDS && q.pw2 == prep_cks
              && q.pw1 != 16'h0000 && q.pw1 <= rtrsv_pkg::READBACK_MAX) begin
            next_q.wbuf[0] = q.pw0;
            next_q.addr = q.pw0;
            next_q.left = q.pw1[5:0];
            next_q.widx = 6'h01;
            next_q.st = rtrsv_pkg::S_R_RD;
          end
        end
      end
      rtrsv_pkg::S_R_RD: begin
        if (mem_ready) begin
          next_q.mem_re = 1'b1;
          next_q.mem_addr = q.addr;
          next_q.st = rtrsv_pkg::S_R_WAIT;
        end
      end
      rtrsv_pkg::S_R_WAIT: begin
        next_q.st = rtrsv_pkg::S_R_CAP;
      end
      rtrsv_pkg::S_R_CAP: begin
        next_q.wbuf[q.widx[4:0]] = mem_rdata;
        next_q.widx = q.widx + 6'h01;
        next_q.addr = q.addr + rtrsv_pkg::ADDR_STRIDE;
        next_q.left = q.left - 6'h01;
        next_q.st = (q.left == 6'h01) ? rtrsv_pkg::S_IDLE : rtrsv_pkg::S_R_RD;
      end
    endcase

    // register port
    if (reg_we && reg_addr == rtrsv_pkg::REG_CTRL) begin
      next_q.en = reg_wdata[rtrsv_pkg::CTRL_ENABLE_BIT];
    end
    if (reg_re) begin
      unique case (reg_addr)
        rtrsv_pkg::REG_CTRL: next_q.reg_rdata[rtrsv_pkg::CTRL_ENABLE_BIT] = q.en;
        rtrsv_pkg::REG_STATUS: begin
          next_q.reg_rdata[3:0] = word1[3:0];
          next_q.reg_rdata[rtrsv_pkg::STATUS_WAIT_BIT] = q.waitf;
          next_q.reg_rdata[rtrsv_pkg::STATUS_BUSY_BIT] = (q.st != rtrsv_pkg::S_IDLE);
        end
        rtrsv_pkg::REG_LOADS: next_q.reg_rdata = q.loads;
        default: next_q.reg_rdata = 16'h0000;
      endcase
    end

    next_q.resp_status = 16'h0000;
    next_q.resp_status[rtrsv_pkg::WAIT_BIT] = next_q.waitf;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.st <= rtrsv_pkg::S_IDLE;
      q.txk <= rtrsv_pkg::K_NONE;
      q.en <= rtrsv_pkg::CTRL_ENABLE_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign tx_word = q.tx_word;
  assign tx_valid = q.tx_valid;
  assign resp_status = q.resp_status;
  assign mem_addr = q.mem_addr;
  assign mem_wdata = q.mem_wdata;
  assign mem_we = q.mem_we;
  assign mem_re = q.mem_re;
  assign reg_rdata = q.reg_rdata;
endmodule
